// [common/cluster_defs.svh]
// Constants for the shared arithmetic cluster datapath
`ifndef CLUSTER_DEFS_SVH
`define CLUSTER_DEFS_SVH
`define MODULES_PER_CLUSTER 8
`define HALF_CLUSTER        4
`define BITS_PER_MODULE     2
`define FIRST_START_IDX     0
`define FIFTH_START_IDX     4
`endif

// [common/cluster_pkg.sv]
// Types for the shared arithmetic cluster datapath
package cluster_pkg;
  typedef enum logic [1:0] {
    MODE_FULL,
    MODE_LOWER_HALF,
    MODE_UPPER_HALF
  } chain_mode_t;
endpackage : cluster_pkg

// [src/shared_arith_cluster.sv]
// One logic cluster: shared arithmetic three-operand adder and register chain
`timescale 1ns/100ps
`default_nettype none
`include "cluster_defs.svh"

// Function
// - Cluster holds eight logic modules with carry, shared and register chains.
// - Register chain passes each module register output to the adjacent module register.
// - Shared mode adds three operands with four four-input look-up tables per module.
// - Each look-up table yields either the sum or carry of three bits.
// - Shared carry goes to second stage, or next module's first stage.
// - Shared arithmetic chain begins only at first or fifth module.
// - Chains beyond sixteen bits continue into the next cluster down the column.
// - Half-cluster chain carries into same half of the next cluster.
// - Alternate columns bypass upper half, others bypass lower half.
module shared_arith_cluster #(
  parameter int MODULES  = `MODULES_PER_CLUSTER,
  parameter bit UPPER_BYPASS_COL = 1'b0
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    arst_n_i,
  input  wire cluster_pkg::chain_mode_t mode_i,
  input  wire logic                    start_fifth_i,
  input  wire logic [2*MODULES-1:0]    op_a_i,
  input  wire logic [2*MODULES-1:0]    op_b_i,
  input  wire logic [2*MODULES-1:0]    op_c_i,
  input  wire logic                    link_in_i,
  input  wire logic                    share_in_i,
  input  wire logic                    carry_in_i,
  input  wire logic                    reg_chain_i,
  output logic [2*MODULES-1:0]         sum_o,
  output logic                         share_out_o,
  output logic                         carry_out_o,
  output logic [MODULES-1:0]           reg_chain_o
);

  localparam int W    = 2 * MODULES;
  localparam int BPM  = `BITS_PER_MODULE;
  localparam int HALF = `HALF_CLUSTER;
  localparam int MID  = `FIFTH_START_IDX * `BITS_PER_MODULE;

  // ==========================================
  // Elaboration checks
  // Chain entry points and the half split are wired for an eight-module cluster
  if (MODULES != `MODULES_PER_CLUSTER) begin : g_bad_size
    $error("Cluster must hold eight logic modules");
  end

  // Each module holds exactly a first and a second adder stage
  if (BPM != 2) begin : g_bad_bits
    $error("Each logic module must carry two sum bits");
  end

  // The fifth-module entry must sit on the half boundary
  if (`FIFTH_START_IDX != HALF || `FIRST_START_IDX != 0) begin : g_bad_start
    $error("Chain entries must be the first and fifth modules");
  end

  // Half-cluster chains need two equal halves
  if (2 * HALF != MODULES) begin : g_bad_half
    $error("Half cluster must be half of the modules");
  end

  // ==========================================
  // Look-up table primitives
  function automatic logic lut_sum(input logic a, input logic b, input logic c);
    lut_sum = a ^ b ^ c;
  endfunction : lut_sum

  function automatic logic lut_carry(input logic a, input logic b, input logic c);
    lut_carry = (a & b) | (a & c) | (b & c);
  endfunction : lut_carry

  // Is module m in a half that takes part in the current chain
  function automatic logic half_active(input int m, input logic lo, input logic hi);
    half_active = (m < HALF) ? lo : hi;
  endfunction : half_active

  // ==========================================
  // State
  // One packed word: sums, outgoing carries and the register chain

  typedef struct packed {
    logic [W-1:0]       sum;
    logic               share_out;
    logic               carry_out;
    logic [MODULES-1:0] regs;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // ==========================================
  // Internal nets
  wire logic [W-1:0]       s_term;
  wire logic [W-1:0]       maj;
  logic [W:0]              sh;
  logic [W:0]              cy;
  logic [W-1:0]            res;
  wire logic [MODULES-1:0] first_adder_stage;
  wire logic [MODULES-1:0] second_adder_stage;
  logic                    lo_used;
  logic                    hi_used;
  logic                    hi_start;
  logic                    hi_link;

  // ==========================================
  // Chain configuration
  always_comb begin
    lo_used  = 1'b1;
    hi_used  = 1'b1;
    hi_start = start_fifth_i;
    // Only an upper-half chain may take the link carries at the fifth module
    hi_link  = 1'b0;
    unique case (mode_i)
      cluster_pkg::MODE_FULL: begin
        lo_used = ~start_fifth_i;
      end
      cluster_pkg::MODE_LOWER_HALF: begin
        hi_used  = 1'b0;
        hi_start = 1'b0;
      end
      cluster_pkg::MODE_UPPER_HALF: begin
        lo_used  = 1'b0;
        hi_start = 1'b1;
        hi_link  = link_in_i;
      end
      default: begin
        lo_used = 1'b1;
      end
    endcase
    // Only the half this column may bypass can be left unused
    if (UPPER_BYPASS_COL) begin
      lo_used = 1'b1;
    end else begin
      hi_used = 1'b1;
    end
  end

  // ==========================================
  // Shared arithmetic datapath
  // Four tables per module: a sum and a carry table for each adder stage
  for (genvar m = 0; m < MODULES; m++) begin : g_module
    // First adder stage tables
    assign s_term[BPM*m]   = lut_sum(op_a_i[BPM*m], op_b_i[BPM*m], op_c_i[BPM*m]);
    assign maj[BPM*m]      = lut_carry(op_a_i[BPM*m], op_b_i[BPM*m], op_c_i[BPM*m]);
    // Second adder stage tables
    assign s_term[BPM*m+1] = lut_sum(op_a_i[BPM*m+1], op_b_i[BPM*m+1], op_c_i[BPM*m+1]);
    assign maj[BPM*m+1]    = lut_carry(op_a_i[BPM*m+1], op_b_i[BPM*m+1], op_c_i[BPM*m+1]);
    // Stage results as the module's register sees them
    assign first_adder_stage[m]  = res[BPM*m];
    assign second_adder_stage[m] = res[BPM*m+1];
  end

  // Adder ripple: each bit adds its sum term, the shared term and the ripple carry
  always_comb begin
    sh  = '0;
    cy  = '0;
    res = '0;
    // Chain entry: zero unless linked from the cluster above
    sh[0] = link_in_i ? share_in_i : 1'b0;
    cy[0] = link_in_i ? carry_in_i : 1'b0;
    for (int i = 0; i < W; i++) begin
      // Fifth-module entry cuts both chains at the half boundary
      if (i == MID && hi_start) begin
        sh[i] = hi_link ? share_in_i : 1'b0;
        cy[i] = hi_link ? carry_in_i : 1'b0;
      end
      res[i]  = s_term[i] ^ sh[i] ^ cy[i];
      // Shared term feeds the next stage: second stage here or next module's first
      sh[i+1] = maj[i];
      cy[i+1] = lut_carry(s_term[i], sh[i], cy[i]);
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    for (int m = 0; m < MODULES; m++) begin
      // Modules of a bypassed half stay free for other logic and read zero
      if (half_active(m, lo_used, hi_used)) begin
        nxt_state.sum[m*2 +: 2] = {second_adder_stage[m], first_adder_stage[m]};
      end else begin
        nxt_state.sum[m*2 +: 2] = 2'h0;
      end
    end
    // Lower-half chain hands off from the fourth module when this column bypasses the upper half, otherwise from the eighth
    if (mode_i == cluster_pkg::MODE_LOWER_HALF && !hi_used) begin
      nxt_state.share_out = sh[`HALF_CLUSTER * `BITS_PER_MODULE];
      nxt_state.carry_out = cy[`HALF_CLUSTER * `BITS_PER_MODULE];
    end else begin
      nxt_state.share_out = sh[W];
      nxt_state.carry_out = cy[W];
    end
    nxt_state.regs = {state_ff.regs[MODULES-2:0], reg_chain_i};
  end

  // ==========================================
  // State register
  // Clear only to constants, so reset never depends on the operands
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // Outputs
  // Every output is a flop bit, so the next cluster sees settled values
  assign sum_o       = state_ff.sum;
  assign share_out_o = state_ff.share_out;
  assign carry_out_o = state_ff.carry_out;
  assign reg_chain_o = state_ff.regs;

endmodule : shared_arith_cluster
`default_nettype wire

// [test/cluster_above_model.sv]
// Cluster above: register chain source
`timescale 1ns/100ps
`default_nettype none
module cluster_above_model (
  input  wire logic clk_sys_i,
  output logic      reg_bit_o = 1'b0
);
  // Toggling each clock makes every chain stage differ from its neighbour
  always @(posedge clk_sys_i) reg_bit_o <= ~reg_bit_o;
endmodule : cluster_above_model
`default_nettype wire

// [test/arith_checker.sv]
// Cluster adder and register chain assertions
`timescale 1ns/100ps
`default_nettype none
module arith_checker #(parameter int MODULES = 8) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire cluster_pkg::chain_mode_t mode_i,
  input wire logic start_fifth_i,
  input wire logic link_in_i,
  input wire logic reg_chain_i,
  input wire logic [2*MODULES-1:0] op_a_i,
  input wire logic [2*MODULES-1:0] op_b_i,
  input wire logic [2*MODULES-1:0] op_c_i,
  input wire logic [2*MODULES-1:0] sum_o,
  input wire logic [MODULES-1:0] reg_chain_o
);
  localparam int H = MODULES;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire [2*H-1:0] t = op_a_i + op_b_i + op_c_i;
  wire [H-1:0] u = op_a_i[2*H-1:H] + op_b_i[2*H-1:H] + op_c_i[2*H-1:H];
  // Reset edge excluded: flops still clear there
  wire f = arst_n_i && !link_in_i && mode_i == cluster_pkg::MODE_FULL;
  wire f0 = f && !start_fifth_i;
  wire up = arst_n_i && !link_in_i && mode_i == cluster_pkg::MODE_UPPER_HALF;
  property p_sum; f0 |=> sum_o == $past(t); endproperty
  a_sum: assert property (p_sum) else $error("bad sum");
  property p_b0; f0 |=> sum_o[0] == $past(op_a_i[0] ^ op_b_i[0] ^ op_c_i[0]); endproperty
  a_b0: assert property (p_b0) else $error("bad bit 0");
  property p_hi; f0 |=> sum_o[2*H-1:H] == $past(t[2*H-1:H]); endproperty
  a_hi: assert property (p_hi) else $error("bad upper");
  property p_up; up |=> sum_o == {$past(u), {H{1'b0}}}; endproperty
  a_up: assert property (p_up) else $error("bad half");
  property p_5th; f && start_fifth_i |=> sum_o[2*H-1:H] == $past(u); endproperty
  a_5th: assert property (p_5th) else $error("bad fifth");
  property p_rc0; arst_n_i |=> reg_chain_o[0] == $past(reg_chain_i); endproperty
  a_rc0: assert property (p_rc0) else $error("bad chain in");
  property p_rcs; arst_n_i |=> reg_chain_o[H-1:1] == $past(reg_chain_o[H-2:0]); endproperty
  a_rcs: assert property (p_rcs) else $error("bad shift");
  property p_rst; disable iff (1'b0) !arst_n_i |-> sum_o == '0 && reg_chain_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  c_up: cover property (up);
  c_5th: cover property (f && start_fifth_i);
  c_full: cover property (f0);
endmodule : arith_checker
bind shared_arith_cluster arith_checker #(.MODULES(MODULES)) i_chk (.clk_sys_i, .arst_n_i, .mode_i,
  .start_fifth_i, .link_in_i, .reg_chain_i, .op_a_i, .op_b_i, .op_c_i, .sum_o, .reg_chain_o);
`default_nettype wire

// [test/shared_arithmetic_adder_chain_test.sv]
// Bench for the shared arithmetic cluster
`timescale 1ns/100ps
`default_nettype none
module shared_arithmetic_adder_chain_test;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b1, start_fifth_i = 1'b0;
  cluster_pkg::chain_mode_t mode_i = cluster_pkg::MODE_FULL;
  logic [15:0] op_a_i = 16'h0, op_b_i = 16'h0, op_c_i = 16'h0;
  logic link_in_i = 1'b0, share_in_i = 1'b0, carry_in_i = 1'b0;
  wire logic reg_chain_i, share_out_o, carry_out_o;
  wire logic [15:0] sum_o;
  wire logic [7:0] reg_chain_o;
  int failures = 0, comparisons = 0, cyc = 0;
  logic [63:0] rows [3] = '{64'hffff_0001_0000_0000, 64'h5555_aaaa_ffff_fffe, 64'h1234_4321_0f0f_6464};
  cluster_above_model i_cluster_above_model (.clk_sys_i, .reg_bit_o(reg_chain_i));
  shared_arith_cluster i_shared_arith_cluster (.clk_sys_i, .arst_n_i, .mode_i, .start_fifth_i, .op_a_i,
    .op_b_i, .op_c_i, .link_in_i, .share_in_i, .carry_in_i, .reg_chain_i, .sum_o,
    .share_out_o, .carry_out_o, .reg_chain_o);
  initial forever #50 clk_sys_i = ~clk_sys_i;
  task give_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 200) begin
      failures++;
      give_verdict();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chk_c(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t carries got %h want %h", $time, got, exp);
    end
  endtask : chk_c
  task run(input cluster_pkg::chain_mode_t md, input logic sf, input logic [2:0] lk, input logic [47:0] ops);
    @(posedge clk_sys_i);
    mode_i <= md;
    start_fifth_i <= sf;
    {link_in_i, share_in_i, carry_in_i} <= lk;
    {op_a_i, op_b_i, op_c_i} <= ops;
    @(negedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : run
  initial begin
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      run(cluster_pkg::MODE_FULL, 1'b0, 3'h0, rows[i][63:16]);
      chk(sum_o, rows[i][15:0]);
    end
    run(cluster_pkg::MODE_FULL, 1'b0, 3'h0, 48'hffff_ffff_ffff);
    chk(sum_o, 16'hfffd);
    chk_c({1'b0, share_out_o} + {1'b0, carry_out_o}, 2'h2);
    run(cluster_pkg::MODE_FULL, 1'b0, 3'h7, 48'h0001_0000_0000);
    chk(sum_o, 16'h0003);
    run(cluster_pkg::MODE_LOWER_HALF, 1'b0, 3'h0, 48'h1234_4321_0f0f);
    chk(sum_o, 16'h6464);
    run(cluster_pkg::MODE_UPPER_HALF, 1'b0, 3'h0, 48'h1280_3481_0001);
    chk(sum_o, 16'h4600);
    run(cluster_pkg::MODE_UPPER_HALF, 1'b0, 3'h7, 48'h1280_3481_0001);
    chk(sum_o, 16'h4800);
    run(cluster_pkg::MODE_FULL, 1'b1, 3'h0, 48'h1280_3481_0001);
    chk(sum_o, 16'h4600);
    chk({8'h00, reg_chain_o}, reg_chain_i ? 16'h00aa : 16'h0055);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(sum_o | {8'h00, reg_chain_o}, 16'h0000);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    run(cluster_pkg::MODE_FULL, 1'b0, 3'h0, rows[2][63:16]);
    chk(sum_o, rows[2][15:0]);
    give_verdict();
  end
endmodule : shared_arithmetic_adder_chain_test
`default_nettype wire
